// ===== hdl/sgc_pkg.sv
// sgc_pkg: constants, field layout and carrier types for the sgmii
// control/status management register pair and its mdio slave.
// assumes one core clock; no other files depend on anything outside it.
package sgc_pkg;

  // ********************************************************
  // register addresses
  // ********************************************************
  localparam logic [4:0] SGC_ADDR_CONTROL = 5'h00;
  localparam logic [4:0] SGC_ADDR_STATUS = 5'h01;

  // ********************************************************
  // control register fields
  // ********************************************************
  localparam int SGC_CTL_POWER_DOWN = 11;
  localparam int SGC_CTL_ISOLATE = 10;
  localparam int SGC_CTL_AN_RESTART = 9;
  localparam int SGC_CTL_DUPLEX = 8;
  localparam int SGC_CTL_COL_TEST = 7;
  localparam int SGC_CTL_SPEED_MSB = 6;
  localparam int SGC_CTL_UNIDIR = 5;

  localparam logic SGC_RST_POWER_DOWN = 1'h0;
  localparam logic SGC_RST_ISOLATE = 1'h1;
  localparam logic SGC_RST_AN_RESTART = 1'h0;
  localparam logic SGC_RST_SPEED_MSB = 1'h1;
  localparam logic SGC_RST_UNIDIR = 1'h0;
  localparam logic SGC_FIX_DUPLEX = 1'h1;
  localparam logic SGC_FIX_COL_TEST = 1'h0;
  localparam logic SGC_FIX_SPEED_MSB = 1'h1;

  // ********************************************************
  // status register fields
  // ********************************************************
  localparam int SGC_STS_EXT_STATUS = 8;
  localparam int SGC_STS_UNIDIR_ABL = 7;
  localparam int SGC_STS_PREAMBLE_SUP = 6;
  localparam int SGC_STS_LINK = 2;
  localparam logic SGC_RST_LINK = 1'h0;

  // ********************************************************
  // mdio frame layout
  // ********************************************************
  localparam logic [1:0] SGC_OP_READ = 2'h2;
  localparam logic [1:0] SGC_OP_WRITE = 2'h1;
  localparam logic [4:0] SGC_HDR_LAST = 5'h0b;
  localparam logic [4:0] SGC_DATA_LAST = 5'h0f;
  localparam logic [4:0] SGC_WR_TA_LAST = 5'h01;
  localparam logic [4:0] SGC_SKIP_LAST = 5'h11;

  typedef enum {
    SGC_IDLE, SGC_START, SGC_HDR, SGC_RD_TA, SGC_RD_DATA, SGC_RD_END,
    SGC_WR_TA, SGC_WR_DATA, SGC_SKIP
  } sgc_state_t;

  // control lines toward the pcs datapath
  typedef struct packed {
    logic power_down;
    logic isolate;
    logic an_restart;
    logic speed_msb;
    logic unidir_en;
  } sgc_ctrl_t;

  // mdio pin as seen by the module
  typedef struct packed {
    logic mdio_o;
    logic mdio_oe;
  } sgc_mdio_out_t;

endpackage

// ===== hdl/sgc_regs.sv
// sgc_regs: sgmii control and status registers behind an mdio slave.
// assumes mdc and mdio_i are already synchronous to clk and that mdc is
// well below clk/4; the mdio wire level is resolved outside.
`timescale 1ns/1ps

module sgc_regs
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // extra reset sources
  input wire logic clk_locked,
  input wire logic soft_reset,
  // configuration straps
  input wire logic tbi_variant,
  input wire logic gem_mode,
  input wire logic [4:0] phy_addr,
  // link state from the pcs
  input wire logic link_up,
  // management interface
  input wire logic mdc,
  input wire logic mdio_i,
  output sgc_pkg::sgc_mdio_out_t mdio_q,
  // control toward the datapath
  output sgc_pkg::sgc_ctrl_t ctrl_q
);
  import sgc_pkg::*;

  // ********************************************************
  // register state
  // ********************************************************
  logic pd_q;
  logic iso_q;
  logic restart_q;
  logic speed_q;
  logic unidir_q;
  logic link_q;

  sgc_state_t state_q;
  logic mdc_q;
  logic [4:0] cnt_q;
  logic [11:0] hdr_q;
  logic [15:0] sh_q;

  logic mdc_rise;
  logic [11:0] hdr_d;
  logic [15:0] sh_in_d;
  logic wr_stb;
  logic rd_stat;
  logic core_clr;
  logic wr_ctrl;

  assign mdc_rise = mdc & ~mdc_q;
  assign hdr_d = {hdr_q[10:0], mdio_i};
  assign sh_in_d = {sh_q[14:0], mdio_i};
  assign core_clr = ~clk_locked | soft_reset;

  // ********************************************************
  // read value of each register
  // ********************************************************
  // speed msb as the station reads it and as the datapath sees it; one
  // decode so the two can never disagree
  function automatic logic speed_bit(input logic gem, input logic stored);
    return gem ? stored : SGC_FIX_SPEED_MSB;
  endfunction

  function automatic logic [15:0] read_word(input logic [4:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    if (addr == SGC_ADDR_CONTROL) begin
      w[SGC_CTL_POWER_DOWN] = pd_q;
      w[SGC_CTL_ISOLATE] = iso_q;
      w[SGC_CTL_AN_RESTART] = restart_q;
      w[SGC_CTL_DUPLEX] = SGC_FIX_DUPLEX;
      w[SGC_CTL_COL_TEST] = SGC_FIX_COL_TEST;
      w[SGC_CTL_SPEED_MSB] = speed_bit(gem_mode, speed_q);
      w[SGC_CTL_UNIDIR] = unidir_q;
    end else if (addr == SGC_ADDR_STATUS) begin
      w[SGC_STS_EXT_STATUS] = 1'h1;
      w[SGC_STS_UNIDIR_ABL] = 1'h1;
      w[SGC_STS_PREAMBLE_SUP] = 1'h1;
      w[SGC_STS_LINK] = link_q;
    end
    return w;
  endfunction

  // ********************************************************
  // mdio frame sequencer
  // ********************************************************
  // writes land on the edge that samples the last data bit
  assign wr_stb = mdc_rise && (state_q == SGC_WR_DATA) &&
                  (cnt_q == SGC_DATA_LAST);
  // status read is committed when the turnaround is driven
  assign rd_stat = mdc_rise && (state_q == SGC_RD_TA) &&
                   (hdr_q[4:0] == SGC_ADDR_STATUS);
  // only the control address takes writes; status and unused addresses
  // drop theirs
  assign wr_ctrl = wr_stb && (hdr_q[4:0] == SGC_ADDR_CONTROL);

  // a rise seen straight after reset meets an idle high line and opens
  // no frame

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdc_q <= 1'h0;
    end else begin
      mdc_q <= mdc;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SGC_IDLE;
      cnt_q <= 5'h00;
      hdr_q <= 12'h000;
      sh_q <= 16'h0000;
    end else if (mdc_rise) begin
      case (state_q)
        // idle line is high; a zero then a one opens a frame, with or
        // without preamble ahead of it
        SGC_IDLE: begin
          if (!mdio_i) begin
            state_q <= SGC_START;
          end
        end
        SGC_START: begin
          state_q <= mdio_i ? SGC_HDR : SGC_START;
          cnt_q <= 5'h00;
        end
        SGC_HDR: begin
          hdr_q <= hdr_d;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SGC_HDR_LAST) begin
            cnt_q <= 5'h00;
            // the last header bit is folded in through hdr_d, not hdr_q
            if (hdr_d[9:5] != phy_addr) begin
              state_q <= SGC_SKIP;
            end else if (hdr_d[11:10] == SGC_OP_READ) begin
              state_q <= SGC_RD_TA;
            end else if (hdr_d[11:10] == SGC_OP_WRITE) begin
              state_q <= SGC_WR_TA;
            end else begin
              state_q <= SGC_SKIP;
            end
          end
        end
        SGC_RD_TA: begin
          // the pin driver turns the line around on this same rise
          sh_q <= read_word(hdr_q[4:0]);
          state_q <= SGC_RD_DATA;
        end
        SGC_RD_DATA: begin
          sh_q <= {sh_q[14:0], 1'h0};
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SGC_DATA_LAST) begin
            state_q <= SGC_RD_END;
          end
        end
        SGC_RD_END: begin
          state_q <= SGC_IDLE;
        end
        SGC_WR_TA: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SGC_WR_TA_LAST) begin
            cnt_q <= 5'h00;
            state_q <= SGC_WR_DATA;
          end
        end
        SGC_WR_DATA: begin
          sh_q <= sh_in_d;
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SGC_DATA_LAST) begin
            state_q <= SGC_IDLE;
          end
        end
        // frame for another address or a bad opcode: stay off the wire to its end
        SGC_SKIP: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == SGC_SKIP_LAST) begin
            state_q <= SGC_IDLE;
          end
        end
        default: begin
          state_q <= SGC_IDLE;
        end
      endcase
    end
  end

  // ********************************************************
  // mdio pin driver
  // ********************************************************
  // the pin moves on the same mdc rise as the sequencer, so each bit is
  // launched one rise before the station samples it; outside a read the
  // line is left released
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mdio_q <= '0;
    end else if (mdc_rise) begin
      case (state_q)
        SGC_RD_TA: begin
          mdio_q.mdio_oe <= 1'h1;
          mdio_q.mdio_o <= 1'h0;
        end
        SGC_RD_DATA: begin
          mdio_q.mdio_o <= sh_q[15];
        end
        default: begin
          mdio_q <= '0;
        end
      endcase
    end
  end

  // ********************************************************
  // control register
  // ********************************************************
  // a core reset outranks a write that lands in the same clk
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_q <= SGC_RST_POWER_DOWN;
      iso_q <= SGC_RST_ISOLATE;
      restart_q <= SGC_RST_AN_RESTART;
      speed_q <= SGC_RST_SPEED_MSB;
      unidir_q <= SGC_RST_UNIDIR;
    end else if (core_clr) begin
      pd_q <= SGC_RST_POWER_DOWN;
      iso_q <= SGC_RST_ISOLATE;
      restart_q <= SGC_RST_AN_RESTART;
      speed_q <= SGC_RST_SPEED_MSB;
      unidir_q <= SGC_RST_UNIDIR;
    end else begin
      restart_q <= 1'h0;
      if (wr_ctrl) begin
        // a written zero cannot wake the transceiver again
        pd_q <= pd_q | sh_in_d[SGC_CTL_POWER_DOWN];
        iso_q <= sh_in_d[SGC_CTL_ISOLATE];
        restart_q <= sh_in_d[SGC_CTL_AN_RESTART];
        unidir_q <= sh_in_d[SGC_CTL_UNIDIR];
        if (gem_mode) begin
          speed_q <= sh_in_d[SGC_CTL_SPEED_MSB];
        end
      end
    end
  end

  // ********************************************************
  // status register: only the latched link bit holds state
  // ********************************************************
  // writes to the status address are never decoded here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_q <= SGC_RST_LINK;
    end else if (core_clr) begin
      link_q <= SGC_RST_LINK;
    end else if (rd_stat) begin
      // a drop in the reload clk loads zero, so no loss slips past a read
      link_q <= link_up;
    end else begin
      link_q <= link_q & link_up;
    end
  end

  // ********************************************************
  // datapath controls, registered
  // ********************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // outputs sit at the register defaults through reset, so the client
      // side stays isolated until the core is up
      ctrl_q.power_down <= SGC_RST_POWER_DOWN;
      ctrl_q.isolate <= SGC_RST_ISOLATE;
      ctrl_q.an_restart <= SGC_RST_AN_RESTART;
      ctrl_q.speed_msb <= SGC_FIX_SPEED_MSB;
      ctrl_q.unidir_en <= SGC_RST_UNIDIR;
    end else begin
      ctrl_q.power_down <= pd_q & ~tbi_variant;
      ctrl_q.isolate <= iso_q;
      ctrl_q.an_restart <= restart_q;
      ctrl_q.speed_msb <= speed_bit(gem_mode, speed_q);
      ctrl_q.unidir_en <= unidir_q;
    end
  end

endmodule // sgc_regs

// ===== tb/sgc_regs_assertions.sv
// sgc_regs_assertions: port checks for the sgmii control/status block.
// assumes mdc is slow against clk, as the bench station drives it.
`timescale 1ns/1ps
module sgc_regs_chk
  import sgc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // straps and reset sources
  input wire logic clk_locked,
  input wire logic soft_reset,
  input wire logic tbi_variant,
  input wire logic gem_mode,
  // management and control
  input wire logic mdc,
  input wire sgc_pkg::sgc_mdio_out_t mdio_q,
  input wire sgc_pkg::sgc_ctrl_t ctrl_q
);
  // ********************************************************
  // properties
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RST_DEF: assert property ($rose(rst_b) |=> ctrl_q.isolate
    && !ctrl_q.power_down && !ctrl_q.unidir_en) else $error("bad reset");
  AST_SYNC_DEF: assert property ((!clk_locked || soft_reset)[*3]
    |-> ctrl_q.isolate && !ctrl_q.unidir_en) else $error("bad sync rst");
  AST_PD_STICKY: assert property ($fell(ctrl_q.power_down) |->
    !$past(clk_locked, 2) || $past(soft_reset, 2) || $past(tbi_variant))
    else $error("power down cleared");
  AST_TBI_PD: assert property (tbi_variant && $past(tbi_variant)
    && $past(tbi_variant, 2) |-> !ctrl_q.power_down) else $error("tbi pd");
  AST_SPEED: assert property ($past(rst_b) && !$past(gem_mode)
    && !$past(gem_mode, 2) |-> ctrl_q.speed_msb) else $error("speed msb");
  AST_RESTART: assert property ($rose(ctrl_q.an_restart) |=>
    !ctrl_q.an_restart) else $error("restart not one clk");
  AST_OE_RISE: assert property ($rose(mdio_q.mdio_oe) |->
    $past(mdc) && !$past(mdc, 2) && !mdio_q.mdio_o) else $error("ta2");
  AST_OE_HOLD: assert property ($rose(mdio_q.mdio_oe) |=>
    mdio_q.mdio_oe[*8]) else $error("oe dropped");
  AST_DATA_EDGE: assert property ($changed(mdio_q.mdio_o) |->
    $past(mdc) && !$past(mdc, 2)) else $error("data off mdc rise");
endmodule // sgc_regs_chk

bind sgc_regs sgc_regs_chk i_sgc_regs_chk(.clk(clk), .rst_b(rst_b),
  .clk_locked(clk_locked), .soft_reset(soft_reset), .mdc(mdc),
  .tbi_variant(tbi_variant), .gem_mode(gem_mode), .mdio_q(mdio_q),
  .ctrl_q(ctrl_q));

// ===== tb/sgc_station.sv
// sgc_station: behavioural mdio management station.
// assumes the bench resolves the wire, with a pull-up when released.
`timescale 1ns/1ps
module sgc_station
  import sgc_pkg::*;
(
  // core clock
  input wire logic clk,
  // mdio pins
  output logic mdc,
  output logic drv_en,
  output logic drv_o,
  input wire logic mdio_lvl
);
  // ********************************************************
  // frame tasks
  // ********************************************************
  initial begin
    mdc = 1'h0;
    drv_en = 1'h0;
    drv_o = 1'h0;
  end
  // own drive changes only in the low half; sampled just before mdc rises,
  // since the device launches each bit on the rise before
  task automatic mbit(input logic en, input logic v, output logic s);
    @(negedge clk);
    mdc = 1'h0;
    drv_en = en;
    drv_o = v;
    repeat (3) @(negedge clk);
    s = mdio_lvl;
    mdc = 1'h1;
    repeat (3) @(negedge clk);
  endtask
  // no preamble sent, frames start at the start bits
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'h1, op, pa, ra, 2'h2, wd};
    for (int i = 31; i >= 0; i--) begin
      mbit(!(op == SGC_OP_READ && i < 18), f[i], s);
      if (i < 16) rd[i] = s;
    end
    mbit(1'h0, 1'h1, s);
  endtask
endmodule // sgc_station

// ===== tb/test_sgc_regs.sv
// test_sgc_regs: self-checking bench for the control/status pair.
// assumes sgc_station drives the management side.
`timescale 1ns/1ps
module test_sgc_regs;
  import sgc_pkg::*;
  // ********************************************************
  // harness
  // ********************************************************
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic clk_locked = 1'h1;
  logic soft_reset = 1'h0;
  logic tbi_variant = 1'h0;
  logic gem_mode = 1'h0;
  logic link_up = 1'h1;
  logic [4:0] phy_addr = 5'h03;
  logic mdc, drv_en, drv_o, lvl;
  sgc_mdio_out_t mdio_q;
  sgc_ctrl_t ctrl_q;
  int n_errors = 0;
  int checks = 0;
  int n_rs = 0;
  always #2.5 clk = ~clk;
  assign lvl = mdio_q.mdio_oe ? mdio_q.mdio_o : (drv_en ? drv_o : 1'h1);
  always @(posedge clk) if (ctrl_q.an_restart === 1'h1) n_rs++;
  sgc_regs i_sgc_regs(.clk(clk), .rst_b(rst_b), .clk_locked(clk_locked),
    .soft_reset(soft_reset), .tbi_variant(tbi_variant),
    .gem_mode(gem_mode), .phy_addr(phy_addr), .link_up(link_up),
    .mdc(mdc), .mdio_i(lvl), .mdio_q(mdio_q), .ctrl_q(ctrl_q));
  sgc_station i_sgc_station(.clk(clk), .mdc(mdc), .drv_en(drv_en),
    .drv_o(drv_o), .mdio_lvl(lvl));
  task automatic cmp(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] r;
    i_sgc_station.frame(SGC_OP_WRITE, phy_addr, ra, d, r);
  endtask
  task automatic rc(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] r;
    i_sgc_station.frame(SGC_OP_READ, phy_addr, ra, 16'h0000, r);
    cmp($sformatf("reg%0d", ra), e, r);
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task t_defaults;
    rc(SGC_ADDR_CONTROL, 16'h0540);
    rc(SGC_ADDR_STATUS, 16'h01c0);
    rc(SGC_ADDR_STATUS, 16'h01c4);
  endtask
  task t_ctrl_write;
    wr(SGC_ADDR_CONTROL, 16'hffff);
    cmp("restarts", 16'h0001, 16'(n_rs));
    cmp("ctrl out", 16'h001b, 16'(ctrl_q));
    rc(SGC_ADDR_CONTROL, 16'h0d60);
    wr(SGC_ADDR_CONTROL, 16'h0000);
    rc(SGC_ADDR_CONTROL, 16'h0940);
    cmp("ctrl out", 16'h0012, 16'(ctrl_q));
  endtask
  task t_status_ro;
    logic [15:0] r;
    wr(SGC_ADDR_STATUS, 16'h0000);
    rc(SGC_ADDR_STATUS, 16'h01c4);
    wr(5'h05, 16'hffff);
    rc(5'h05, 16'h0000);
    i_sgc_station.frame(SGC_OP_READ, phy_addr + 5'h01, 5'h00, 16'h0, r);
    cmp("other phy", 16'hffff, r);
  endtask
  task t_link;
    link_up = 1'h0;
    repeat (3) @(negedge clk);
    link_up = 1'h1;
    rc(SGC_ADDR_STATUS, 16'h01c0);
    rc(SGC_ADDR_STATUS, 16'h01c4);
    link_up = 1'h0;
    rc(SGC_ADDR_STATUS, 16'h01c0);
    rc(SGC_ADDR_STATUS, 16'h01c0);
    link_up = 1'h1;
  endtask
  task t_gem;
    gem_mode = 1'h1;
    wr(SGC_ADDR_CONTROL, 16'h0000);
    rc(SGC_ADDR_CONTROL, 16'h0900);
    cmp("speed out", 16'h0000, 16'(ctrl_q.speed_msb));
    gem_mode = 1'h0;
    rc(SGC_ADDR_CONTROL, 16'h0940);
    cmp("speed out", 16'h0001, 16'(ctrl_q.speed_msb));
  endtask
  task t_tbi;
    tbi_variant = 1'h1;
    rc(SGC_ADDR_CONTROL, 16'h0940);
    cmp("pd out", 16'h0000, 16'(ctrl_q.power_down));
    tbi_variant = 1'h0;
    repeat (4) @(negedge clk);
    cmp("pd out", 16'h0001, 16'(ctrl_q.power_down));
  endtask
  task t_resets;
    // soft reset, lost lock, then the reset pin in mid-run
    for (int k = 0; k < 3; k++) begin
      wr(SGC_ADDR_CONTROL, 16'h0820);
      soft_reset = (k == 0);
      clk_locked = (k != 1);
      rst_b = (k != 2);
      repeat (3) @(negedge clk);
      soft_reset = 1'h0;
      clk_locked = 1'h1;
      rst_b = 1'h1;
      rc(SGC_ADDR_CONTROL, 16'h0540);
      rc(SGC_ADDR_STATUS, 16'h01c0);
    end
    cmp("ctrl out", 16'h000a, 16'(ctrl_q));
  endtask
  // ********************************************************
  // run control
  // ********************************************************
  task stop_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    cmp("ctrl in rst", 16'h000a, 16'(ctrl_q));
    cmp("mdio in rst", 16'h0000, 16'(mdio_q));
    rst_b = 1'h1;
    repeat (2) @(negedge clk);
    t_defaults;
    t_ctrl_write;
    t_status_ro;
    t_link;
    t_gem;
    t_tbi;
    t_resets;
    stop_test;
  end
  // about 29 frames of some 231 clk each; allow nearly three times that
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test;
  end
endmodule // test_sgc_regs
